// *** design/bcr_regs.sv ***
// Register bank and start-up sequencer of the buck regulator controller.
// Assumes a serial engine on the same clock drives the register port,
// and the analog loop drives the condition pins asynchronously.
//
// Function
// - Live status bits follow their conditions continuously.
// - Fault flags set on their condition and hold until cleared.
// - Bit 0 latches on output under 70% while current limiting.
// - Bit 1 latches on output 20% above target.
// - Bit 2 latches when the thermal detector trips.
// - Bit 3 latches when inductor current reaches its limit.
// - Bit 4 latches on feedback under 80% while not current limiting.
// - Bit 5 latches if feedback misses 90% within soft start.
// - Power good waits a tenth of the soft-start time.
// - Bit 6 shows discontinuous conduction, allowed only with power save.
// - Bit 6 also reads one while shut down, during the power-on delay and during soft start.
// - Bit 7 reads one exactly while power good is not pulled low.
// - Switching enable zero keeps both switch drives off.
// - Delay and soft start run only with enable bit and pin high.
// - Fault-clear write clears six flags, then the bit self-clears.
// - Internal load pulls the output down while slewing down.
// - Frequency field selects 250k, 500k, 750k or 1MHz.
// - Power-on delay: zero, then 250us doubling up to 16ms.
// - Soft start: 250us doubling to 16ms at 110; 111 also 16ms.
// - Ultrasonic floor code, split over two registers, selects 6.25-25kHz.
`timescale 1ns/10ps
`default_nettype none

module bcr_regs
  import bcr_pkg::*;
#(
  parameter int STEP_CYC = BCR_STEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port from the serial engine
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Analog loop conditions (asynchronous)
  input wire logic i_en_pin,
  input wire logic i_out_below_70,
  input wire logic i_out_above_120,
  input wire logic i_thermal_trip,
  input wire logic i_current_limit,
  input wire logic i_fb_below_80,
  input wire logic i_fb_above_90,
  input wire logic i_in_window,
  input wire logic i_discontinuous,
  input wire logic i_slewing_down,
  // Settings toward the analog loop
  output logic o_drive_enable,
  output logic o_soft_start,
  output logic o_power_good,
  output logic [1:0] o_freq_select,
  output logic o_light_load_saver,
  output logic o_ultrasonic_saver,
  output logic [1:0] o_ultrasonic_floor_select,
  output logic o_internal_load_on
);

  bcr_regs_t s_r;
  bcr_regs_t s_nxt;
  bcr_cond_t pins;

  // Soft-start length in cycles; codes above 110 saturate
  function automatic logic [BCR_TMR_W-1:0] ss_cycles(input logic [2:0] code);
    logic [2:0] c;
    c = (code > BCR_SS_MAX_CODE) ? BCR_SS_MAX_CODE : code;
    ss_cycles = BCR_TMR_W'(STEP_CYC) << c;
  endfunction

  // Power-on delay in cycles; code zero means no delay
  function automatic logic [BCR_TMR_W-1:0] pod_cycles(input logic [2:0] code);
    pod_cycles = '0;
    if (code != 3'h0) begin
      pod_cycles = BCR_TMR_W'(STEP_CYC) << (code - 3'h1);
    end
  endfunction

  // Power-good delay: a tenth of soft start, at least one cycle
  function automatic logic [BCR_TMR_W-1:0] pg_cycles(input logic [2:0] code);
    logic [BCR_TMR_W-1:0] t;
    t = ss_cycles(code) / BCR_TMR_W'(BCR_PG_DIV);
    pg_cycles = (t == '0) ? BCR_TMR_W'(1) : t;
  endfunction

  // Gather the pins into one vector for synchronising
  always_comb begin
    pins.en_pin = i_en_pin;
    pins.out_below_70 = i_out_below_70;
    pins.out_above_120 = i_out_above_120;
    pins.thermal_trip = i_thermal_trip;
    pins.current_limit = i_current_limit;
    pins.fb_below_80 = i_fb_below_80;
    pins.fb_above_90 = i_fb_above_90;
    pins.in_window = i_in_window;
    pins.discontinuous = i_discontinuous;
    pins.slewing_down = i_slewing_down;
  end

  // Next-state logic for the whole block
  always_comb begin
    logic [5:0] events;
    logic [7:0] status;
    logic sw_en;
    logic go;
    logic ps_on;
    bcr_cond_t c;
    events = '0;
    status = '0;
    sw_en = 1'b0;
    go = 1'b0;
    ps_on = 1'b0;
    c = '0;
    s_nxt = s_r;

    // Three-stage synchroniser; a change counts when stages 2 and 3 agree
    s_nxt.sync1 = pins;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    for (int i = 0; i < $bits(bcr_cond_t); i++) begin
      if (s_r.sync2[i] == s_r.sync3[i]) begin
        s_nxt.cond[i] = s_r.sync3[i];
      end
    end
    c = s_r.cond;

    // Register writes; reserved bits stay zero
    s_nxt.clr_pend = 1'b0;
    if (i_reg_wr) begin
      case (i_reg_addr)
        BCR_OFS_SWCTL: begin
          s_nxt.swctl = i_reg_wdata & BCR_MASK_SWCTL;
          s_nxt.clr_pend = i_reg_wdata[BCR_B_FCLR];
        end
        BCR_OFS_TIMA: s_nxt.tima = i_reg_wdata & BCR_MASK_TIM;
        BCR_OFS_TIMB: s_nxt.timb = i_reg_wdata & BCR_MASK_TIM;
        default: ;
      endcase
    end

    sw_en = s_r.swctl[BCR_B_SW_EN];
    go = sw_en && c.en_pin;

    // Sequencer: off, power-on delay, soft start, power-good delay, run
    s_nxt.fb_reached = s_r.fb_reached | c.fb_above_90;
    if (s_r.tmr != '0) begin
      s_nxt.tmr = s_r.tmr - BCR_TMR_W'(1);
    end
    if (!go) begin
      s_nxt.state = BCR_ST_OFF;
      s_nxt.tmr = '0;
    end else begin
      case (s_r.state)
        BCR_ST_OFF: begin
          s_nxt.state = BCR_ST_POD;
          s_nxt.tmr = pod_cycles(s_r.tima[BCR_T_HI:BCR_T_LO]);
        end
        BCR_ST_POD: begin
          if (s_r.tmr == '0) begin
            s_nxt.state = BCR_ST_SS;
            s_nxt.tmr = ss_cycles(s_r.timb[BCR_T_HI:BCR_T_LO]);
            s_nxt.fb_reached = 1'b0;
          end
        end
        BCR_ST_SS: begin
          if (s_r.tmr == '0) begin
            events[BCR_B_DNS] = !s_r.fb_reached;
            s_nxt.state = BCR_ST_PGDLY;
            s_nxt.tmr = pg_cycles(s_r.timb[BCR_T_HI:BCR_T_LO]);
          end
        end
        BCR_ST_PGDLY: begin
          if (s_r.tmr == '0) begin
            s_nxt.state = BCR_ST_RUN;
          end
        end
        BCR_ST_RUN: ;
        default: begin
          s_nxt.state = BCR_ST_OFF;
          s_nxt.tmr = '0;
        end
      endcase
    end

    // Fault events feeding the sticky flags
    events[0] = c.out_below_70 && c.current_limit;
    events[1] = c.out_above_120;
    events[2] = c.thermal_trip;
    events[3] = c.current_limit;
    events[4] = c.fb_below_80 && !c.current_limit;

    // Sticky flags; a new event beats the clear
    for (int i = 0; i < BCR_N_FLAGS; i++) begin
      if (events[i]) begin
        s_nxt.flags[i] = 1'b1;
      end else if (s_r.clr_pend) begin
        s_nxt.flags[i] = 1'b0;
      end
    end

    // Settings driven toward the analog loop
    ps_on = (s_r.timb[BCR_F_HI:BCR_F_LO] == BCR_PSV_LIGHT) ||
            (s_r.timb[BCR_F_HI:BCR_F_LO] == BCR_PSV_ULTRA);
    s_nxt.drive_en = go && (s_r.state != BCR_ST_OFF)
                     && (s_r.state != BCR_ST_POD);
    // Soft start drops together with the drives when switching is withdrawn
    s_nxt.soft_start = go && (s_r.state == BCR_ST_SS);
    s_nxt.power_good = (s_r.state == BCR_ST_RUN) && c.in_window;
    s_nxt.freq = s_r.tima[BCR_F_HI:BCR_F_LO];
    s_nxt.light_saver = (s_r.timb[BCR_F_HI:BCR_F_LO] == BCR_PSV_LIGHT);
    s_nxt.ultra_saver = (s_r.timb[BCR_F_HI:BCR_F_LO] == BCR_PSV_ULTRA);
    s_nxt.ufloor = {s_r.timb[BCR_B_UFLOOR], s_r.tima[BCR_B_UFLOOR]};
    s_nxt.iload_on = s_r.swctl[BCR_B_ILOAD] && c.slewing_down;

    // Status word: sticky flags plus live bits
    status[5:0] = s_r.flags;
    status[BCR_B_DCM] = (s_r.state == BCR_ST_OFF) || (s_r.state == BCR_ST_POD)
                || (s_r.state == BCR_ST_SS)
                || (ps_on && c.discontinuous);
    status[BCR_B_PGD] = s_r.power_good;

    // Read data, held until the next read
    if (i_reg_rd) begin
      case (i_reg_addr)
        BCR_OFS_STATUS: s_nxt.rdata = status;
        BCR_OFS_SWCTL: s_nxt.rdata = s_r.swctl;
        BCR_OFS_TIMA: s_nxt.rdata = s_r.tima;
        BCR_OFS_TIMB: s_nxt.rdata = s_r.timb;
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.flags <= BCR_RST_STATUS[5:0];
      s_r.swctl <= BCR_RST_SWCTL;
      s_r.tima <= BCR_RST_TIMA;
      s_r.timb <= BCR_RST_TIMB;
      s_r.state <= BCR_ST_OFF;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flip-flops
  assign o_reg_rdata = s_r.rdata;
  assign o_drive_enable = s_r.drive_en;
  assign o_soft_start = s_r.soft_start;
  assign o_power_good = s_r.power_good;
  assign o_freq_select = s_r.freq;
  assign o_light_load_saver = s_r.light_saver;
  assign o_ultrasonic_saver = s_r.ultra_saver;
  assign o_ultrasonic_floor_select = s_r.ufloor;
  assign o_internal_load_on = s_r.iload_on;

endmodule // bcr_regs

`default_nettype wire

// *** design/bcr_pkg.sv ***
// Package for the buck controller register bank: offsets, fields,
// reset values, timing constants, sequencer states and carrier types.
// Assumes a 10 MHz core clock and an external serial engine.
package bcr_pkg;

  // Register offsets
  localparam logic [7:0] BCR_OFS_STATUS = 8'h00; // converter_status
  localparam logic [7:0] BCR_OFS_SWCTL = 8'h01;  // switching_control
  localparam logic [7:0] BCR_OFS_TIMA = 8'h02;   // timing_control_a
  localparam logic [7:0] BCR_OFS_TIMB = 8'h03;   // timing_control_b

  // Reset values
  localparam logic [7:0] BCR_RST_STATUS = 8'h40;
  localparam logic [7:0] BCR_RST_SWCTL = 8'h01;
  localparam logic [7:0] BCR_RST_TIMA = 8'h20;
  localparam logic [7:0] BCR_RST_TIMB = 8'h2e;

  // Writable bits; the rest read as zero
  localparam logic [7:0] BCR_MASK_SWCTL = 8'h05;
  localparam logic [7:0] BCR_MASK_TIM = 8'h3f;

  // Field positions
  localparam int BCR_B_SW_EN = 0;
  localparam int BCR_B_FCLR = 1;
  localparam int BCR_B_ILOAD = 2;
  localparam int BCR_B_UFLOOR = 5;
  localparam int BCR_F_LO = 0; // Freq / power save field, bits 1:0
  localparam int BCR_F_HI = 1;
  localparam int BCR_T_LO = 2; // Delay / soft-start field, bits 4:2
  localparam int BCR_T_HI = 4;
  localparam int BCR_B_DNS = 5; // Start-failure flag in the status word
  localparam int BCR_B_DCM = 6; // Discontinuous status bit
  localparam int BCR_B_PGD = 7; // Power-good status bit
  localparam int BCR_N_FLAGS = 6; // Count of sticky fault flags

  // Power-save codes
  localparam logic [1:0] BCR_PSV_LIGHT = 2'h1;
  localparam logic [1:0] BCR_PSV_ULTRA = 2'h2;

  // Soft-start code that already reaches the longest time
  localparam logic [2:0] BCR_SS_MAX_CODE = 3'h6;
  // Power-good delay is this fraction of soft start
  localparam int BCR_PG_DIV = 10;

  // Timing: base step of the delay ladders
  localparam int BCR_CLK_HZ = 10_000_000;
  localparam int BCR_STEP_US = 250;
  localparam int BCR_STEP_CYC = (BCR_STEP_US * (BCR_CLK_HZ / 1_000_000));
  localparam int BCR_TMR_W = 24;

  // Sequencer states
  typedef enum logic [4:0] {
    BCR_ST_OFF = 5'h01,
    BCR_ST_POD = 5'h02,
    BCR_ST_SS = 5'h04,
    BCR_ST_PGDLY = 5'h08,
    BCR_ST_RUN = 5'h10
  } bcr_state_t;

  // Conditions reported by the analog loop
  typedef struct packed {
    logic en_pin;        // External enable pin
    logic out_below_70;  // Output under 70% of target
    logic out_above_120; // Output 20% above target
    logic thermal_trip;  // Thermal detector tripped
    logic current_limit; // Inductor current at limit
    logic fb_below_80;   // Feedback under falling power-good level
    logic fb_above_90;   // Feedback over rising power-good level
    logic in_window;     // Output within +/-20% of regulation
    logic discontinuous; // Loop running in discontinuous conduction
    logic slewing_down;  // Output being slewed downward
  } bcr_cond_t;

  // Whole module state
  typedef struct packed {
    bcr_cond_t sync1;
    bcr_cond_t sync2;
    bcr_cond_t sync3;
    bcr_cond_t cond;
    logic [5:0] flags;
    logic clr_pend;
    logic [7:0] swctl;
    logic [7:0] tima;
    logic [7:0] timb;
    bcr_state_t state;
    logic [BCR_TMR_W-1:0] tmr;
    logic fb_reached;
    logic power_good;
    logic drive_en;
    logic soft_start;
    logic light_saver;
    logic ultra_saver;
    logic [1:0] ufloor;
    logic [1:0] freq;
    logic iload_on;
    logic [7:0] rdata;
  } bcr_regs_t;

endpackage : bcr_pkg

// *** verif/bcr_regs_asserts.sv ***
// Checker for the register bank: timing and decode relations at its ports.
// Assumes it is bound onto bcr_regs and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module bcr_regs_asserts
  import bcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_en_pin,
  input wire logic i_in_window,
  input wire logic o_drive_enable,
  input wire logic o_soft_start,
  input wire logic o_power_good,
  input wire logic [1:0] o_freq_select,
  input wire logic o_light_load_saver,
  input wire logic o_ultrasonic_saver,
  input wire logic [1:0] o_ultrasonic_floor_select,
  input wire logic o_internal_load_on
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic wr_a;
  logic wr_b;
  logic wr_c;
  // Writes decoded by target register
  assign wr_a = i_reg_wr && i_reg_addr == BCR_OFS_TIMA;
  assign wr_b = i_reg_wr && i_reg_addr == BCR_OFS_TIMB;
  assign wr_c = i_reg_wr && i_reg_addr == BCR_OFS_SWCTL;
  chk_pin_low_off: assert property (!i_en_pin [*8] |-> !o_drive_enable)
    else $error("drive active with pin low");
  chk_swen_off: assert property (wr_c && !i_reg_wdata[0] |-> ##[2:4] !o_drive_enable)
    else $error("drive active with enable bit low");
  chk_ss_drives: assert property (o_soft_start |-> o_drive_enable)
    else $error("soft start without drive");
  chk_pg_window: assert property (!i_in_window [*8] |-> !o_power_good)
    else $error("power good outside window");
  chk_pg_after_ss: assert property (o_power_good |-> !o_soft_start)
    else $error("power good during soft start");
  chk_freq_track: assert property (wr_a |=> ##1 o_freq_select == $past(i_reg_wdata[1:0], 2))
    else $error("frequency select mismatch");
  chk_saver_code: assert property (wr_b |=> ##1
    o_light_load_saver == ($past(i_reg_wdata[1:0], 2) == BCR_PSV_LIGHT) &&
    o_ultrasonic_saver == ($past(i_reg_wdata[1:0], 2) == BCR_PSV_ULTRA))
    else $error("power save decode mismatch");
  chk_floor_hi: assert property (wr_b |=> ##1
    o_ultrasonic_floor_select[1] == $past(i_reg_wdata[5], 2))
    else $error("floor select high bit mismatch");
  chk_clr_reads_zero: assert property (i_reg_rd && i_reg_addr == BCR_OFS_SWCTL
    |=> !o_reg_rdata[1])
    else $error("fault clear bit read as one");
  chk_off_dcm: assert property (!o_drive_enable [*3] ##0 (i_reg_rd && i_reg_addr == 8'h00)
    |=> o_reg_rdata[6])
    else $error("status bit6 low while off");
  cov_pg: cover property ($rose(o_power_good));
  cov_iload: cover property ($rose(o_internal_load_on));
  cov_clear: cover property (wr_c && i_reg_wdata[BCR_B_FCLR]);
endmodule // bcr_regs_asserts
`default_nettype wire

// *** verif/bcr_loop_model.sv ***
// Behavioural model of the analog loop facing the register bank.
// Assumes the bench supplies fault levels and the enable pin.
`timescale 1ns/10ps
`default_nettype none
module bcr_loop_model
  import bcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_drive_enable,
  input wire logic i_soft_start,
  input wire logic i_start_ok,
  input wire bcr_cond_t i_faults,
  output var bcr_cond_t o_cond
);
  logic fb_up_r;
  // Feedback climbs one cycle into soft start unless told to stall
  always_ff @(posedge i_clk) begin
    fb_up_r <= i_drive_enable && i_start_ok && (fb_up_r || i_soft_start);
  end
  // Bench faults, loop levels from the model; idle loop is discontinuous
  always_comb begin
    o_cond = i_faults;
    o_cond.fb_above_90 = fb_up_r;
    o_cond.in_window = fb_up_r && !i_faults.out_above_120;
    o_cond.discontinuous = i_faults.discontinuous || !i_drive_enable;
  end
endmodule // bcr_loop_model
`default_nettype wire

// *** verif/bcr_regs_tb.sv ***
// Self-checking bench for the register bank with the loop model.
// Assumes a shortened delay step so start-up runs stay brief.
`timescale 1ns/10ps
`default_nettype none
module bcr_regs_tb
  import bcr_pkg::*;
;
  localparam int STEP = 4;
  typedef struct {string nm; logic [7:0] v; logic [7:0] m;} bcr_note_t;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic rd_en = 1'b0;
  logic rd_seen = 1'b0;
  logic start_ok = 1'b1;
  bcr_cond_t faults = '0;
  bcr_cond_t cond;
  logic [7:0] rdata;
  logic drv, ss, pg, lsav, usav, iload;
  logic [1:0] freq, ufl;
  logic [7:0] rv, tv;
  bcr_note_t notes[$];
  int fail_count = 0;
  int samples_checked = 0;
  int tp[5], ts[5], tg[5];
  logic [9:0] fpat[6] = '{10'h130, 10'h080, 10'h040, 10'h020, 10'h010, 10'h110};
  logic [7:0] fexp[6] = '{8'h09, 8'h02, 8'h04, 8'h08, 8'h10, 8'h10};
  logic [2:0] cpod[5] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h1};
  logic [2:0] css[5] = '{3'h4, 3'h4, 3'h5, 3'h6, 3'h7};

  // Free-running 10 MHz clock
  always #50 i_clk = ~i_clk;

  bcr_regs #(.STEP_CYC(STEP)) u_bcr_regs (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr_en),
    .i_reg_wdata(wdata), .i_reg_rd(rd_en), .o_reg_rdata(rdata),
    .i_en_pin(cond.en_pin), .i_out_below_70(cond.out_below_70),
    .i_out_above_120(cond.out_above_120), .i_thermal_trip(cond.thermal_trip),
    .i_current_limit(cond.current_limit), .i_fb_below_80(cond.fb_below_80),
    .i_fb_above_90(cond.fb_above_90), .i_in_window(cond.in_window),
    .i_discontinuous(cond.discontinuous), .i_slewing_down(cond.slewing_down),
    .o_drive_enable(drv), .o_soft_start(ss), .o_power_good(pg),
    .o_freq_select(freq), .o_light_load_saver(lsav), .o_ultrasonic_saver(usav),
    .o_ultrasonic_floor_select(ufl), .o_internal_load_on(iload));

  bcr_loop_model u_bcr_loop_model (.i_clk(i_clk), .i_drive_enable(drv),
    .i_soft_start(ss), .i_start_ok(start_ok), .i_faults(faults), .o_cond(cond));

  task automatic cmp(string nm, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge i_clk);
    wr_en <= 1'b0;
  endtask

  // Issue a read and note what the monitor should see
  task automatic rd(logic [7:0] a, logic [7:0] v, logic [7:0] m, string nm);
    @(posedge i_clk);
    addr <= a;
    rd_en <= 1'b1;
    notes.push_back('{nm, v, m});
    @(posedge i_clk);
    rd_en <= 1'b0;
  endtask

  // Start up with given codes and count phase lengths
  task automatic start_run(logic [2:0] pc, logic [2:0] sc, output int a, b, c);
    wr(BCR_OFS_TIMA, {3'h0, pc, 2'h0});
    wr(BCR_OFS_TIMB, {3'h0, sc, 2'h0});
    a = 0;
    b = 0;
    c = 0;
    faults.en_pin <= 1'b1;
    while (ss !== 1'b1 && a < 999) begin @(negedge i_clk); a++; end
    while (ss === 1'b1 && b < 999) begin @(negedge i_clk); b++; end
    while (pg !== 1'b1 && c < 999) begin @(negedge i_clk); c++; end
    cmp("start limit", 8'h00, {5'h0, a >= 999, b >= 999, c >= 999});
    rd(BCR_OFS_STATUS, 8'h80, 8'hc0, "running");
    faults.en_pin <= 1'b0;
    idle(10);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Monitor: compare each returned byte with the oldest note
  always @(posedge i_clk) rd_seen <= rd_en && !i_rst;
  always @(negedge i_clk) begin
    if (rd_seen && notes.size() > 0) begin
      cmp(notes[0].nm, notes[0].v & notes[0].m, rdata & notes[0].m);
      void'(notes.pop_front());
    end
  end

  // Watchdog
  initial begin
    idle(20000);
    fail_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h2676173d));
    idle(12);
    i_rst <= 1'b0;
    rd(BCR_OFS_STATUS, BCR_RST_STATUS, 8'hff, "status");
    rd(BCR_OFS_SWCTL, BCR_RST_SWCTL, 8'hff, "swctl");
    rd(BCR_OFS_TIMA, BCR_RST_TIMA, 8'hff, "tima");
    rd(BCR_OFS_TIMB, BCR_RST_TIMB, 8'hff, "timb");
    wr(BCR_OFS_STATUS, 8'hff);
    rd(8'h05, 8'h00, 8'hff, "unmapped");
    rd(BCR_OFS_STATUS, 8'h40, 8'hff, "status ro");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      rv = 8'($urandom) & BCR_MASK_TIM;
      tv = 8'($urandom) & BCR_MASK_TIM;
      wr(BCR_OFS_TIMA, {rv[7:2], i[1:0]});
      wr(BCR_OFS_TIMB, {tv[7:2], i[1:0]});
      idle(3);
      @(negedge i_clk);
      cmp("freq", {6'h0, i[1:0]}, {6'h0, freq});
      cmp("savers", {6'h0, i == 2, i == 1}, {6'h0, usav, lsav});
      cmp("floor", {6'h0, tv[5], rv[5]}, {6'h0, ufl});
      rd(BCR_OFS_TIMB, {tv[7:2], i[1:0]}, 8'hff, "timb rw");
    end
    $display("test fields done");
    for (int k = 0; k < 6; k++) begin
      faults <= bcr_cond_t'(fpat[k]);
      idle(8);
      faults <= '0;
      idle(8);
      rd(BCR_OFS_STATUS, fexp[k], 8'h3f, "flags");
      wr(BCR_OFS_SWCTL, 8'h03);
      idle(4);
      rd(BCR_OFS_STATUS, 8'h00, 8'h3f, "cleared");
    end
    rd(BCR_OFS_SWCTL, 8'h01, 8'hff, "swctl");
    faults <= bcr_cond_t'(10'h040);
    idle(8);
    wr(BCR_OFS_SWCTL, 8'h03);
    idle(4);
    faults <= '0;
    idle(8);
    rd(BCR_OFS_STATUS, 8'h04, 8'h3f, "kept");
    wr(BCR_OFS_SWCTL, 8'h03);
    // Thermal pulse timed so its last event cycle meets the pending clear
    faults <= bcr_cond_t'(10'h040);
    idle(2);
    faults <= '0;
    idle(1);
    wr(BCR_OFS_SWCTL, 8'h03);
    idle(8);
    rd(BCR_OFS_STATUS, 8'h04, 8'h3f, "kept edge");
    wr(BCR_OFS_SWCTL, 8'h03);
    $display("test flags done");
    for (int j = 0; j < 5; j++) start_run(cpod[j], css[j], tp[j], ts[j], tg[j]);
    cmp("pod step", 8'(STEP), 8'(tp[1] - tp[0]));
    cmp("pod double", 8'(STEP), 8'(tp[2] - tp[1]));
    cmp("ss double", 8'(STEP * 16), 8'(ts[2] - ts[1]));
    cmp("ss top", 8'h00, 8'(ts[4] - ts[3]));
    cmp("pg delay", 8'((STEP * 32) / 10 - (STEP * 16) / 10), 8'(tg[2] - tg[1]));
    $display("test startup done");
    faults <= bcr_cond_t'(10'h202);
    idle(400);
    rd(BCR_OFS_STATUS, 8'h80, 8'hc0, "dcm off");
    wr(BCR_OFS_TIMB, 8'h1d);
    idle(6);
    rd(BCR_OFS_STATUS, 8'hc0, 8'hc0, "dcm on");
    faults <= bcr_cond_t'(10'h203);
    wr(BCR_OFS_SWCTL, 8'h05);
    idle(8);
    @(negedge i_clk);
    cmp("iload", 8'h01, {7'h0, iload});
    wr(BCR_OFS_SWCTL, 8'h00);
    idle(8);
    @(negedge i_clk);
    cmp("drive off", 8'h00, {6'h0, drv, iload});
    rd(BCR_OFS_STATUS, 8'h40, 8'h40, "dcm shut");
    start_ok <= 1'b0;
    wr(BCR_OFS_TIMA, 8'h00);
    wr(BCR_OFS_TIMB, 8'h00);
    wr(BCR_OFS_SWCTL, 8'h01);
    idle(40);
    rd(BCR_OFS_STATUS, 8'h20, 8'ha0, "no start");
    $display("test modes done");
    // Reset in mid-run clears the sticky flags and restores the registers
    i_rst <= 1'b1;
    idle(2);
    i_rst <= 1'b0;
    rd(BCR_OFS_STATUS, BCR_RST_STATUS, 8'hff, "status rst");
    rd(BCR_OFS_TIMA, BCR_RST_TIMA, 8'hff, "tima rst");
    $display("test reset again done");
    idle(4);
    print_verdict();
  end
endmodule // bcr_regs_tb
bind bcr_regs bcr_regs_asserts u_bcr_regs_asserts (.*);
`default_nettype wire
